// file: hw/bdsc_pkg.sv
// Purpose: Constants for the debug status, clock and security block
// Assumes: 10 MHz mclk, byte-wide register port
// Notes: Offsets are the documented byte addresses
package bdsc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] ADDR_STATUS = 16'hFF01;
  localparam logic [15:0] ADDR_CCR_HOLD = 16'hFF06;
  localparam logic [15:0] ADDR_REG_SHADOW = 16'hFF07;
  localparam logic [15:0] ADDR_WIN_LO = 16'hFF00;
  // ****************************************
  // Status register fields
  // ****************************************
  localparam int BIT_ENABLE = 7;
  localparam int BIT_ACTIVE = 6;
  localparam int BIT_TAG = 5;
  localparam int BIT_SDV = 4;
  localparam int BIT_TRACE = 3;
  localparam int BIT_CLKSEL = 2;
  localparam int BIT_UNSECURE_FLAG = 1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CCR_RESET_SSC = 8'hD8;
  localparam logic [7:0] CCR_RESET_CPU = 8'hD0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ****************************************
  // Shadow layout: base bits 14:11 at 6:3
  // ****************************************
  localparam int SHADOW_LSB = 3;
  localparam int BASE_LSB = 11;
  localparam int BASE_W = 4;
  // ****************************************
  // Clock switch delay
  // ****************************************
  localparam int SWITCH_CYCLES = 150;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] SWITCH_LAST = CNT_W'(SWITCH_CYCLES - 1);
  // ****************************************
  // Debug clock sources and command origins
  // ****************************************
  typedef enum logic [1:0] {
    BDSC_CLK_BUS,
    BDSC_CLK_ALT,
    BDSC_CLK_PLL
  } bdsc_clk_src_t;
  typedef enum logic [1:0] {
    BDSC_SRC_HW,
    BDSC_SRC_FW,
    BDSC_SRC_SECFW,
    BDSC_SRC_CPU
  } bdsc_origin_t;
endpackage

// file: hw/bdsc_status_security.sv
// Purpose: Debug status, clock selection, security and CONDITION_CODE holding logic
// Assumes: Inputs synchronous to mclk; serial protocol lives outside
// Notes: Register writes arrive tagged with the command origin
module bdsc_status_security (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Mode and system inputs
  input wire logic special_single_chip,
  input wire logic pll_select,
  input wire logic [7:0] condition_code,
  input wire logic [15:0] register_space_base,
  input wire logic cpu_debug_request,
  input wire logic cpu_exit_debug,
  // Register access port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire bdsc_pkg::bdsc_origin_t reg_origin,
  output logic [7:0] reg_rdata,
  // Command gating
  input wire logic cmd_valid,
  input wire logic cmd_is_firmware,
  input wire logic cmd_is_background,
  output logic cmd_accept,
  output logic cmd_reject,
  // Clock selection, maps, flags and held condition code
  output bdsc_pkg::bdsc_clk_src_t debug_clock,
  output logic clock_switching,
  output logic std_table_mapped,
  output logic secure_table_mapped,
  output logic debug_active_flag,
  output logic unsecure_flag,
  output logic [7:0] ccr_restore
);
  // ****************************************
  // State
  // ****************************************
  logic debug_enable_q;
  logic active_q;
  logic unsecure_flag_q;
  logic clksel_q;
  logic tag_q;
  logic [7:0] ccr_q;
  logic [7:0] ccr_d;
  logic [7:0] rdata_q;
  bdsc_pkg::bdsc_clk_src_t clk_q;
  bdsc_pkg::bdsc_clk_src_t clk_d;
  logic [bdsc_pkg::CNT_W-1:0] cnt_q;
  logic switching_q;
  logic secure_map_q;
  logic accept_q;
  logic reject_q;

  // ****************************************
  // Decode signals
  // ****************************************
  logic from_hw;
  logic from_fw;
  logic from_secfw;
  logic from_cpu;
  logic wr_status;
  logic wr_ccr;
  logic hw_wr;
  logic unsecure_flag_wr;
  logic active_clear;
  logic enter;
  logic ccr_fix;
  logic switch_start;
  logic switch_done;
  logic fw_allowed;
  logic accept_d;
  logic reject_d;
  logic [7:0] status_byte;
  logic [7:0] shadow_byte;

  // ****************************************
  // Write decode
  // ****************************************
  assign from_hw = (reg_origin == bdsc_pkg::BDSC_SRC_HW);
  assign from_fw = (reg_origin == bdsc_pkg::BDSC_SRC_FW);
  assign from_secfw = (reg_origin == bdsc_pkg::BDSC_SRC_SECFW);
  assign from_cpu = (reg_origin == bdsc_pkg::BDSC_SRC_CPU);
  assign wr_status = reg_wr && (reg_addr == bdsc_pkg::ADDR_STATUS);
  assign wr_ccr = reg_wr && (reg_addr == bdsc_pkg::ADDR_CCR_HOLD);
  // Only the hardware command path may move the clock select
  assign hw_wr = wr_status && from_hw;
  // Secure firmware in special single-chip mode owns the unsecure bit
  assign unsecure_flag_wr = wr_status && special_single_chip && from_secfw;
  // Standard firmware exit store, or the CPU exit sequence
  assign active_clear = cpu_exit_debug
    || (wr_status && from_fw && !reg_wdata[bdsc_pkg::BIT_ACTIVE]);

  // ****************************************
  // Activation decode
  // ****************************************
  // Activation via background command or CPU request, only when enabled
  assign enter = debug_enable_q && !active_q
    && ((cmd_valid && cmd_is_background) || cpu_debug_request);

  // ****************************************
  // Clock source decode
  // ****************************************
  always_comb begin
    if (!pll_select) begin
      clk_d = bdsc_pkg::BDSC_CLK_BUS;
    end else if (!clksel_q) begin
      clk_d = bdsc_pkg::BDSC_CLK_ALT;
    end else begin
      clk_d = bdsc_pkg::BDSC_CLK_PLL;
    end
  end

  // ****************************************
  // Clock-select bit
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clksel_q <= 1'b0;
    end else if (hw_wr) begin
      clksel_q <= reg_wdata[bdsc_pkg::BIT_CLKSEL];
    end
  end

  // ****************************************
  // Switch delay and applied source
  // ****************************************
  // A new target starts one delay; the old source keeps timing until it ends
  assign switch_start = (clk_d != clk_q) && !switching_q;
  assign switch_done = switching_q && (cnt_q == bdsc_pkg::SWITCH_LAST);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      switching_q <= 1'b0;
    end else if (switch_start) begin
      switching_q <= 1'b1;
    end else if (switch_done) begin
      switching_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (switch_start) begin
      cnt_q <= '0;
    end else if (switching_q && !switch_done) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Serial timing and the acknowledge follow the applied source
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clk_q <= bdsc_pkg::BDSC_CLK_BUS;
    end else if (switch_done) begin
      clk_q <= clk_d;
    end
  end

  // ****************************************
  // Enable, tag and active flags
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      debug_enable_q <= 1'b0;
    end else if (wr_status && !from_cpu) begin
      debug_enable_q <= reg_wdata[bdsc_pkg::BIT_ENABLE];
    end
  end

  // Entry clears tagging unless a non-CPU status write lands in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tag_q <= 1'b0;
    end else if (wr_status && !from_cpu) begin
      tag_q <= reg_wdata[bdsc_pkg::BIT_TAG];
    end else if (enter) begin
      tag_q <= 1'b0;
    end
  end

  // Entry wins over an exit request in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      active_q <= 1'b0;
    end else if (enter) begin
      active_q <= 1'b1;
    end else if (active_clear) begin
      active_q <= 1'b0;
    end
  end

  // ****************************************
  // Security
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      unsecure_flag_q <= 1'b0;
    end else if (unsecure_flag_wr) begin
      unsecure_flag_q <= reg_wdata[bdsc_pkg::BIT_UNSECURE_FLAG];
    end
  end

  // In special single-chip mode the secure table stays in the map until secure firmware sets the unsecure bit
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      secure_map_q <= 1'b0;
    end else if (!special_single_chip || unsecure_flag_q) begin
      secure_map_q <= 1'b0;
    end else begin
      secure_map_q <= 1'b1;
    end
  end

  // ****************************************
  // CONDITION_CODE holding register
  // ****************************************
  // Special single-chip mode replaces the CPU reset value whenever it is held while inactive
  assign ccr_fix = special_single_chip && !active_q
    && (ccr_q == bdsc_pkg::CCR_RESET_CPU);

  // Host writes beat the capture on entry
  always_comb begin
    ccr_d = ccr_q;
    if (wr_ccr) begin
      ccr_d = reg_wdata;
    end else if (enter) begin
      ccr_d = condition_code;
    end else if (ccr_fix) begin
      ccr_d = bdsc_pkg::CCR_RESET_SSC;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ccr_q <= bdsc_pkg::CCR_RESET_CPU;
    end else begin
      ccr_q <= ccr_d;
    end
  end

  // ****************************************
  // Command gating
  // ****************************************
  // Firmware needs active mode and no secure lockout
  assign fw_allowed = active_q && !secure_map_q;
  // Tagging shuts the serial side for every command
  assign accept_d = cmd_valid && !tag_q
    && (!cmd_is_firmware || fw_allowed);
  assign reject_d = cmd_valid
    && (tag_q || (cmd_is_firmware && !fw_allowed));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      accept_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      accept_q <= accept_d;
      reject_q <= reject_d;
    end
  end

  // ****************************************
  // Read data assembly
  // ****************************************
  always_comb begin
    status_byte = bdsc_pkg::BYTE_ZERO;
    status_byte[bdsc_pkg::BIT_ENABLE] = debug_enable_q;
    status_byte[bdsc_pkg::BIT_ACTIVE] = active_q;
    status_byte[bdsc_pkg::BIT_TAG] = tag_q;
    status_byte[bdsc_pkg::BIT_CLKSEL] = clksel_q;
    status_byte[bdsc_pkg::BIT_UNSECURE_FLAG] = unsecure_flag_q;
  end

  // Base bits 14:11 land on 6:3; the rest read as zero
  for (genvar i = 0; i < $bits(shadow_byte); i++) begin : g_shadow
    if ((i >= bdsc_pkg::SHADOW_LSB)
      && (i < bdsc_pkg::SHADOW_LSB + bdsc_pkg::BASE_W)) begin : g_base
      assign shadow_byte[i] =
        register_space_base[i - bdsc_pkg::SHADOW_LSB + bdsc_pkg::BASE_LSB];
    end else begin : g_zero
      assign shadow_byte[i] = 1'b0;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= bdsc_pkg::BYTE_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        bdsc_pkg::ADDR_STATUS: begin
          rdata_q <= status_byte;
        end
        bdsc_pkg::ADDR_CCR_HOLD: begin
          rdata_q <= ccr_q;
        end
        bdsc_pkg::ADDR_REG_SHADOW: begin
          rdata_q <= shadow_byte;
        end
        default: begin
          rdata_q <= bdsc_pkg::BYTE_ZERO;
        end
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = rdata_q;
  assign cmd_accept = accept_q;
  assign cmd_reject = reject_q;
  assign debug_clock = clk_q;
  assign clock_switching = switching_q;
  assign std_table_mapped = active_q;
  assign secure_table_mapped = secure_map_q;
  assign debug_active_flag = active_q;
  assign unsecure_flag = unsecure_flag_q;
  assign ccr_restore = ccr_q;
endmodule

// file: verification/bdsc_status_security_checker.sv
// Purpose: Port assertions for the debug status block
// Assumes: Bound to bdsc_status_security
// Notes: Tag bit is never set by the bench
module bdsc_status_security_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Inputs
  input wire logic pll_select,
  input wire logic [7:0] condition_code,
  input wire logic [15:0] register_space_base,
  input wire logic special_single_chip,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire bdsc_pkg::bdsc_origin_t reg_origin,
  input wire logic cmd_valid,
  input wire logic cmd_is_firmware,
  input wire logic cmd_is_background,
  // Outputs
  input wire logic [7:0] reg_rdata,
  input wire logic cmd_accept,
  input wire logic cmd_reject,
  input wire bdsc_pkg::bdsc_clk_src_t debug_clock,
  input wire logic clock_switching,
  input wire logic std_table_mapped,
  input wire logic debug_active_flag,
  input wire logic unsecure_flag,
  input wire logic [7:0] ccr_restore
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [8:0] sw_cnt_q;
  // Cycles spent switching so far
  always_ff @(posedge mclk) begin
    if (sys_rst || !clock_switching) begin
      sw_cnt_q <= 9'h000;
    end else begin
      sw_cnt_q <= sw_cnt_q + 9'h001;
    end
  end
  AST_SWITCH_LEN: assert property ($fell(clock_switching) |-> sw_cnt_q == 9'h096)
    else $error("switch delay length wrong");
  AST_SWITCH_MAX: assert property (clock_switching |-> sw_cnt_q < 9'h096)
    else $error("switch delay too long");
  AST_HOLD_OLD_CLK: assert property (clock_switching |-> $stable(debug_clock))
    else $error("debug clock moved while switching");
  AST_BUS_CLK: assert property (!pll_select && !$past(pll_select) && !$past(pll_select, 2)
    && !clock_switching
    |-> debug_clock == bdsc_pkg::BDSC_CLK_BUS) else $error("bus clock not used");
  AST_ANSWER_ONE: assert property ((cmd_accept || cmd_reject)
    |-> $past(cmd_valid) && !(cmd_accept && cmd_reject)) else $error("bad command answer");
  AST_FW_INACTIVE: assert property (cmd_valid && cmd_is_firmware && !debug_active_flag
    |=> cmd_reject) else $error("firmware command taken while inactive");
  AST_HW_ACCEPT: assert property (cmd_valid && !cmd_is_firmware && !cmd_is_background
    |=> cmd_accept) else $error("hardware command refused");
  AST_CCR_SAVE: assert property ($rose(debug_active_flag)
    |-> ccr_restore == $past(condition_code)) else $error("condition code not saved");
  AST_STD_MAP: assert property (std_table_mapped == debug_active_flag)
    else $error("standard table map differs from active");
  AST_SHADOW_RD: assert property (reg_rd && reg_addr == bdsc_pkg::ADDR_REG_SHADOW
    |=> reg_rdata == {1'h0, $past(register_space_base[14:11]), 3'h0})
    else $error("base shadow read wrong");
  AST_UNSECURE_FLAG_SRC: assert property ($rose(unsecure_flag) |-> $past(reg_wr && special_single_chip
    && reg_origin == bdsc_pkg::BDSC_SRC_SECFW)) else $error("unsecure set by wrong source");
endmodule
bind bdsc_status_security bdsc_status_security_checker bdsc_status_security_checker_i (.*);

// file: verification/bdsc_host_model.sv
// Purpose: Host debugger issuing serial commands
// Assumes: One command per go pulse
// Notes: Idle qualifiers toggle, never hold
module bdsc_host_model (
  // Clock
  input wire logic mclk,
  // Bench request
  input wire logic go,
  input wire logic want_fw,
  input wire logic want_bg,
  // Command lines
  output logic cmd_valid,
  output logic cmd_is_firmware,
  output logic cmd_is_background
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'h0;
    cmd_is_firmware = 1'h0;
    cmd_is_background = 1'h0;
  end
  // Hardware, firmware or background command kinds
  always @(posedge mclk) begin
    cmd_valid <= go;
    cmd_is_firmware <= go ? want_fw : !cmd_is_firmware;
    cmd_is_background <= go ? want_bg : !cmd_is_background;
  end
endmodule

// file: verification/background_debug_status_clock_security_test.sv
// Purpose: Self-checking bench for the debug status block
// Assumes: Special single-chip mode throughout
// Notes: Reads and writes use the byte register port
module background_debug_status_clock_security_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic special_single_chip = 1'h1;
  logic pll_select = 1'h0;
  logic [7:0] condition_code = 8'h5A;
  logic [15:0] register_space_base = 16'h5800;
  logic cpu_debug_request = 1'h0;
  logic cpu_exit_debug = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  bdsc_pkg::bdsc_origin_t reg_origin = bdsc_pkg::BDSC_SRC_HW;
  logic go = 1'h0;
  logic want_fw = 1'h0;
  logic want_bg = 1'h0;
  logic [7:0] reg_rdata, ccr_restore;
  logic cmd_valid, cmd_is_firmware, cmd_is_background, cmd_accept, cmd_reject;
  logic clock_switching, std_table_mapped, secure_table_mapped, debug_active_flag, unsecure_flag;
  bdsc_pkg::bdsc_clk_src_t debug_clock;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  bdsc_status_security bdsc_status_security_i (.*);
  bdsc_host_model bdsc_host_model_i (.mclk(mclk), .go(go), .want_fw(want_fw),
    .want_bg(want_bg), .cmd_valid(cmd_valid), .cmd_is_firmware(cmd_is_firmware),
    .cmd_is_background(cmd_is_background));
  always #50 mclk = ~mclk;
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict;
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input bdsc_pkg::bdsc_origin_t o);
    @(posedge mclk) #1;
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    reg_origin = o;
    @(posedge mclk) #1;
    reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge mclk) #1;
    reg_rd = 1'h1;
    reg_addr = a;
    @(posedge mclk) #1;
    reg_rd = 1'h0;
  endtask
  task automatic cmd(input logic fw, input logic bg);
    @(posedge mclk) #1;
    go = 1'h1;
    want_fw = fw;
    want_bg = bg;
    @(posedge mclk) #1;
    go = 1'h0;
    @(posedge mclk) #1;
  endtask
  task automatic sw(input logic [7:0] d, input bdsc_pkg::bdsc_clk_src_t src);
    int n;
    n = 0;
    wr(bdsc_pkg::ADDR_STATUS, d, bdsc_pkg::BDSC_SRC_HW);
    @(posedge mclk) #1;
    while (clock_switching && n < 200) begin
      @(posedge mclk) #1;
      n++;
    end
    chk("switch cycles", 8'h96, n[7:0]);
    chk("debug clock", src, debug_clock);
  endtask
  task automatic t_reset;
    repeat (6) @(posedge mclk);
    #1 sys_rst = 1'h0;
    repeat (2) @(posedge mclk);
    #1;
    chk("reset ccr", bdsc_pkg::CCR_RESET_SSC, ccr_restore);
    chk("reset unsecure", 8'h00, unsecure_flag);
    chk("secure map", 8'h01, secure_table_mapped);
    chk("reset clock", bdsc_pkg::BDSC_CLK_BUS, debug_clock);
    $display("test reset done");
  endtask
  task automatic t_secure;
    wr(bdsc_pkg::ADDR_STATUS, 8'h02, bdsc_pkg::BDSC_SRC_CPU);
    wr(bdsc_pkg::ADDR_STATUS, 8'h80, bdsc_pkg::BDSC_SRC_SECFW);
    chk("unsecure kept", 8'h00, unsecure_flag);
    cmd(1'h1, 1'h0);
    chk("fw while secure", 8'h01, cmd_reject);
    cmd(1'h0, 1'h0);
    chk("hw while secure", 8'h01, cmd_accept);
    wr(bdsc_pkg::ADDR_STATUS, 8'h82, bdsc_pkg::BDSC_SRC_SECFW);
    chk("unsecure set", 8'h01, unsecure_flag);
    @(posedge mclk) #1;
    chk("secure unmap", 8'h00, secure_table_mapped);
    $display("test secure done");
  endtask
  task automatic t_cmds;
    wr(bdsc_pkg::ADDR_STATUS, 8'h02, bdsc_pkg::BDSC_SRC_HW);
    cmd(1'h0, 1'h1);
    chk("active disabled", 8'h00, debug_active_flag);
    wr(bdsc_pkg::ADDR_STATUS, 8'h82, bdsc_pkg::BDSC_SRC_HW);
    cmd(1'h1, 1'h0);
    chk("fw inactive", 8'h01, cmd_reject);
    cmd(1'h0, 1'h1);
    chk("active enabled", 8'h01, debug_active_flag);
    chk("saved ccr", 8'h5A, ccr_restore);
    cmd(1'h1, 1'h0);
    chk("fw active", 8'h01, cmd_accept);
    wr(bdsc_pkg::ADDR_CCR_HOLD, 8'hC3, bdsc_pkg::BDSC_SRC_HW);
    rd(bdsc_pkg::ADDR_CCR_HOLD);
    chk("ccr readback", 8'hC3, reg_rdata);
    chk("ccr restore", 8'hC3, ccr_restore);
    @(posedge mclk) #1;
    cpu_exit_debug = 1'h1;
    @(posedge mclk) #1;
    cpu_exit_debug = 1'h0;
    chk("exit active", 8'h00, debug_active_flag);
    $display("test commands done");
  endtask
  task automatic t_shadow;
    wr(bdsc_pkg::ADDR_REG_SHADOW, 8'hFF, bdsc_pkg::BDSC_SRC_HW);
    rd(bdsc_pkg::ADDR_REG_SHADOW);
    chk("base shadow", 8'h58, reg_rdata);
    rd(16'hFF03);
    chk("unmapped read", 8'h00, reg_rdata);
    $display("test shadow done");
  endtask
  task automatic t_debug_clock_select;
    pll_select = 1'h1;
    repeat (200) @(posedge mclk);
    #1;
    chk("alt clock", bdsc_pkg::BDSC_CLK_ALT, debug_clock);
    wr(bdsc_pkg::ADDR_STATUS, 8'h86, bdsc_pkg::BDSC_SRC_FW);
    rd(bdsc_pkg::ADDR_STATUS);
    chk("fw clock select", 8'h00, {7'h00, reg_rdata[bdsc_pkg::BIT_CLKSEL]});
    chk("no switch", 8'h00, clock_switching);
    sw(8'h86, bdsc_pkg::BDSC_CLK_PLL);
    sw(8'h82, bdsc_pkg::BDSC_CLK_ALT);
    $display("test clock switch done");
  endtask
  initial begin
    t_reset;
    t_secure;
    t_cmds;
    t_shadow;
    t_debug_clock_select;
    give_verdict;
  end
endmodule
